// >>> verilog/pfs_pkg.sv
// Purpose: shared types and constants for the power fail supervisor
// Assumes: comparator inputs are active high "supply below threshold"
// Notes:   one clock, no software registers
package pfs_pkg;

  // ==========================================================================
  // constants
  localparam logic [7:0] PFS_WARN_VECTOR   = 8'h2b;
  localparam int         PFS_SYNC_STAGES   = 2;
  localparam int         PFS_PERIPH_COUNT  = 4;
  localparam int         PFS_CHIP_EN_COUNT = 4;
  localparam logic [3:0] PFS_BACKED_MASK   = 4'h3;
  localparam logic [3:0] PFS_ALL_INACTIVE  = 4'hf;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    PFS_RUN,
    PFS_WARN,
    PFS_RESET,
    PFS_BACKUP
  } pfs_state_type;

  typedef struct packed {
    logic power_warn_threshold;
    logic min_operating_threshold;
    logic backup_switch_threshold;
  } pfs_level_type;

  typedef struct packed {
    logic [PFS_CHIP_EN_COUNT-1:0] chip_en_n;
    logic [PFS_PERIPH_COUNT-1:0]  periph_en_n;
    logic                         rw_n;
  } pfs_strobe_type;

endpackage

// >>> verilog/pfs_sync.sv
// Purpose: two flop synchroniser for the comparator levels
// Assumes: inputs are slow levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pfs_sync
  import pfs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire pfs_level_type din,
  output logic               dout_unused,
  output pfs_level_type      dout
);

  // ==========================================================================
  // state
  typedef struct packed {
    pfs_level_type meta;
    pfs_level_type sync;
  } pfs_sync_state_type;

  pfs_sync_state_type s_q;
  pfs_sync_state_type s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // reset as if supply is low: safest assumption at power up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout        = s_q.sync;
  assign dout_unused = 1'b0;

endmodule

// >>> verilog/pfs_power_fail_supervisor.sv
// Purpose: supply fall sequencer: warning irq, power fail reset, backup
// Assumes: comparator inputs high while supply is below each threshold
// Notes:   strobes from the core pass through and are forced off in reset
//
// Operation
// - warning below threshold requests vector 2bh interrupt
// - warning never halts, resets or slows core
// - minimum level holds core reset until recovery
// - reset forces chip enables and strobe high
// - below backup threshold switch to battery power
// - drive reset pin low; external low resets
// - backup indication low while on battery
// - backed peripheral selects held high in backup
`timescale 1ns/1ps
module pfs_power_fail_supervisor
  import pfs_pkg::*;
(
  input  wire logic           CLOCK,
  input  wire logic           RST,
  input  wire pfs_level_type  LEVELS_BELOW,
  input  wire logic           WARN_ENABLE,
  input  wire logic           IRQ_ACK,
  input  wire pfs_strobe_type CORE_STROBES,
  input  wire logic           RESET_PIN_IN,
  output logic                RESET_PIN_OUT,
  output logic                RESET_PIN_OE,
  output logic                CORE_RESET,
  output logic                IRQ_REQ,
  output logic [7:0]          IRQ_VECTOR,
  output logic                BATTERY_SELECT,
  output logic                BACKUP_INDICATION_OUT_N,
  output pfs_strobe_type      MEM_STROBES
);

  // ==========================================================================
  // synchronised levels
  pfs_level_type lvl;

  pfs_sync u_sync (
    .clk         (CLOCK),
    .rst         (RST),
    .din         (LEVELS_BELOW),
    .dout_unused (),
    .dout        (lvl)
  );

  // ==========================================================================
  // state
  typedef struct packed {
    pfs_state_type  state;
    logic           irq;
    logic           ext_rst_m;
    logic           ext_rst;
    logic           warn_seen;
    pfs_strobe_type strobes;
  } pfs_top_state_type;

  pfs_top_state_type s_q;
  pfs_top_state_type s_d;

  function automatic pfs_strobe_type forced_off(input pfs_strobe_type s,
                                                input logic backup);
    pfs_strobe_type r;
    r             = s;
    r.chip_en_n   = PFS_ALL_INACTIVE;
    r.rw_n        = 1'b1;
    // only the backed selects are guaranteed once power is gone
    r.periph_en_n = backup ? (s.periph_en_n | PFS_BACKED_MASK) : PFS_ALL_INACTIVE;
    return r;
  endfunction

  logic in_reset;

  always_comb begin
    s_d           = s_q;
    // external pull down on the shared pin, synchronised
    s_d.ext_rst_m = ~RESET_PIN_IN;
    s_d.ext_rst   = s_q.ext_rst_m;
    if (lvl.backup_switch_threshold) begin
      s_d.state = PFS_BACKUP;
    end else if (lvl.min_operating_threshold || s_q.ext_rst) begin
      s_d.state = PFS_RESET;
    end else if (lvl.power_warn_threshold) begin
      s_d.state = PFS_WARN;
    end else begin
      s_d.state = PFS_RUN;
    end
    // one request per fall through the warning level
    case (s_d.state)
      PFS_WARN: begin
        if (WARN_ENABLE && !s_q.warn_seen) begin
          s_d.irq       = 1'b1;
          s_d.warn_seen = 1'b1;
        end else if (IRQ_ACK) begin
          s_d.irq = 1'b0;
        end
      end
      PFS_RUN: begin
        s_d.warn_seen = 1'b0;
        if (IRQ_ACK) begin
          s_d.irq = 1'b0;
        end
      end
      PFS_RESET, PFS_BACKUP: begin
        s_d.irq = 1'b0;
      end
      default: begin
        s_d.irq = 1'b0;
      end
    endcase
    if (s_d.state == PFS_RESET || s_d.state == PFS_BACKUP) begin
      s_d.strobes = forced_off(CORE_STROBES, s_d.state == PFS_BACKUP);
    end else begin
      s_d.strobes = CORE_STROBES;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_q.state     <= PFS_RESET;
      s_q.irq       <= 1'b0;
      s_q.ext_rst_m <= 1'b0;
      s_q.ext_rst   <= 1'b0;
      s_q.warn_seen <= 1'b0;
      s_q.strobes   <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  // warning state keeps the core running; only reset and backup stop it
  assign in_reset                = (s_q.state == PFS_RESET) || (s_q.state == PFS_BACKUP);
  assign CORE_RESET              = in_reset;
  assign RESET_PIN_OUT           = 1'b0;
  assign RESET_PIN_OE            = in_reset;
  assign IRQ_REQ                 = s_q.irq;
  assign IRQ_VECTOR              = PFS_WARN_VECTOR;
  assign BATTERY_SELECT          = (s_q.state == PFS_BACKUP);
  assign BACKUP_INDICATION_OUT_N = ~(s_q.state == PFS_BACKUP);
  assign MEM_STROBES             = s_q.strobes;

endmodule

// >>> verif/pfs_props.sv
// Purpose: port checks for the supervisor
// Assumes: state outputs lag levels by 3 edges
// Notes:   backup state left out of reset checks
`timescale 1ns/1ps
module pfs_props
  import pfs_pkg::*;
(
  input wire logic           CLOCK,
  input wire logic           RST,
  input wire pfs_level_type  LEVELS_BELOW,
  input wire logic           IRQ_ACK,
  input wire logic           RESET_PIN_IN,
  input wire logic           RESET_PIN_OUT,
  input wire logic           RESET_PIN_OE,
  input wire logic           CORE_RESET,
  input wire logic           IRQ_REQ,
  input wire logic [7:0]     IRQ_VECTOR,
  input wire logic           BATTERY_SELECT,
  input wire logic           BACKUP_INDICATION_OUT_N,
  input wire pfs_strobe_type MEM_STROBES
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire logic rst_st = CORE_RESET && !BATTERY_SELECT;
  wire logic bk_lv  = LEVELS_BELOW.backup_switch_threshold;
  // ====
  // assertions
  vector_fixed_a: assert property (IRQ_VECTOR == 8'h2b) else $error("vector");
  warn_no_reset_a: assert property ((LEVELS_BELOW == 3'h4 && RESET_PIN_IN)[*3]
    |=> !CORE_RESET) else $error("warn reset");
  min_reset_a: assert property ((LEVELS_BELOW.min_operating_threshold && !bk_lv)[*3]
    |=> CORE_RESET) else $error("no reset");
  strobe_off_a: assert property (rst_st |-> MEM_STROBES == 9'h1ff) else $error("strobe");
  battery_on_a: assert property (bk_lv[*3] |=> BATTERY_SELECT) else $error("no battery");
  pin_drive_a: assert property (rst_st |-> RESET_PIN_OE && !RESET_PIN_OUT) else $error("pin");
  pin_sense_a: assert property ((!RESET_PIN_IN)[*3] |=> CORE_RESET) else $error("ext");
  backup_ind_a: assert property (BACKUP_INDICATION_OUT_N == !BATTERY_SELECT) else $error("ind");
  backed_sel_a: assert property (BATTERY_SELECT |-> &MEM_STROBES.periph_en_n[1:0])
    else $error("backed");
  reset_irq_a: assert property (CORE_RESET |-> !IRQ_REQ) else $error("irq in reset");
  ack_clear_a: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ) else $error("ack");
  cover property (IRQ_REQ);
  cover property (rst_st);
  cover property (BATTERY_SELECT);
endmodule
bind pfs_power_fail_supervisor pfs_props pfs_props_inst (.CLOCK(CLOCK), .RST(RST),
  .LEVELS_BELOW(LEVELS_BELOW), .IRQ_ACK(IRQ_ACK), .RESET_PIN_IN(RESET_PIN_IN),
  .RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE(RESET_PIN_OE), .CORE_RESET(CORE_RESET),
  .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .BATTERY_SELECT(BATTERY_SELECT),
  .BACKUP_INDICATION_OUT_N(BACKUP_INDICATION_OUT_N), .MEM_STROBES(MEM_STROBES));

// >>> verif/pfs_core_model.sv
// Purpose: core and pin partner
// Assumes: ack level follows request
// Notes:   own oe not looped back, else reset self-holds
`timescale 1ns/1ps
module pfs_core_model
  import pfs_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      irq_req,
  input  wire logic      ext_low,
  output logic           irq_ack,
  output logic           pin_in,
  output pfs_strobe_type strobes
);
  initial irq_ack = 1'b0;
  always @(posedge clk) irq_ack <= #5 irq_req;
  assign pin_in  = !ext_low; // pull-up unless pulled low
  assign strobes = 9'h0a8;
endmodule

// >>> verif/pfs_power_fail_supervisor_bench.sv
// Purpose: scenario bench for the supervisor
// Assumes: levels act 3 edges after a change
// Notes:   core model returns the ack
`timescale 1ns/1ps
module pfs_power_fail_supervisor_bench;
  import pfs_pkg::*;
  logic           clk = 1'b0, rst = 1'b1, warn_en = 1'b0, ext_low = 1'b0;
  pfs_level_type  lvl = '0;
  logic           pin_in, ack, oe, pout, core_rst, irq, bat, ind_n;
  logic [7:0]     vec;
  pfs_strobe_type core_stb, mem_stb, bk;
  int             failures = 0, checked = 0;
  initial forever #25 clk = ~clk;
  pfs_core_model pfs_core_model_inst (.clk(clk), .irq_req(irq), .ext_low(ext_low),
    .irq_ack(ack), .pin_in(pin_in), .strobes(core_stb));
  pfs_power_fail_supervisor pfs_power_fail_supervisor_inst (.CLOCK(clk), .RST(rst),
    .LEVELS_BELOW(lvl), .WARN_ENABLE(warn_en), .IRQ_ACK(ack), .CORE_STROBES(core_stb),
    .RESET_PIN_IN(pin_in), .RESET_PIN_OUT(pout), .RESET_PIN_OE(oe), .CORE_RESET(core_rst),
    .IRQ_REQ(irq), .IRQ_VECTOR(vec), .BATTERY_SELECT(bat),
    .BACKUP_INDICATION_OUT_N(ind_n), .MEM_STROBES(mem_stb));
  // ====
  // helpers
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic tally_and_finish;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_warn_off;
    warn_en = 1'b0;
    lvl = 3'h4;
    cyc(4);
    chk("disabled irq", 0, irq);
    chk("warn core reset", 0, core_rst);
    lvl = '0;
    cyc(3);
  endtask
  task automatic t_warn;
    lvl = 3'h4;
    warn_en = 1'b1;
    cyc(3);
    chk("irq", 1, irq);
    chk("vector", 8'h2b, vec);
    cyc(3);
    chk("acked irq", 0, irq);
    chk("core reset", 0, core_rst);
    chk("strobes", core_stb, mem_stb);
    lvl = '0;
    cyc(3);
  endtask
  task automatic t_min;
    lvl = 3'h6;
    cyc(3);
    chk("core reset", 1, core_rst);
    chk("irq", 0, irq);
    chk("strobes", 9'h1ff, mem_stb);
    chk("pin", 2'h2, {oe, pout});
    lvl = '0;
    cyc(3);
    chk("recovered", 0, core_rst);
  endtask
  task automatic t_bak;
    bk = core_stb;
    bk.chip_en_n = 4'hf;
    bk.rw_n = 1'b1;
    bk.periph_en_n[1:0] = 2'h3;
    lvl = 3'h7;
    cyc(3);
    chk("battery", 1, bat);
    chk("indication", 0, ind_n);
    chk("backup strobes", bk, mem_stb);
    lvl = '0;
    cyc(3);
    chk("indication off", 1, ind_n);
  endtask
  task automatic t_pin;
    ext_low = 1'b1;
    cyc(3);
    chk("external reset", 1, core_rst);
    ext_low = 1'b0;
    cyc(3);
    chk("released", 0, core_rst);
  endtask
  initial begin
    cyc(3);
    chk("reset strobes", 9'h1ff, mem_stb);
    rst = 1'b0;
    cyc(5);
    t_warn_off();
    t_warn();
    t_min();
    t_bak();
    t_pin();
    tally_and_finish();
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
